// *** core/fspc_pkg.sv ***
// Constants and types of the fail-safe switch pre-driver control
package fspc_pkg;

  // ------------------------------------------------------------
  // Geometry and clock
  // ------------------------------------------------------------
  localparam int NCH = 4;
  localparam int CNT_W = 16;
  localparam int CLK_PERIOD_NS = 10;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  // Mask time taken at its typical figure, in ns
  localparam int VDS_MASK_TIME_NS = 110000;
  localparam int VDS_FILTER_TIME_NS = 600;
  localparam int VDS_MASK_CYCLES = VDS_MASK_TIME_NS / CLK_PERIOD_NS;
  localparam int VDS_FILTER_CYCLES_I =
    (VDS_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] VDS_FILTER_CYCLES =
    VDS_FILTER_CYCLES_I[CNT_W-1:0];

  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CFG_BASE = 4'h0;
  localparam logic [3:0] ADDR_CFG_LAST = 4'h3;
  localparam logic [3:0] ADDR_SVC_FAULT = 4'h4;
  localparam logic [3:0] ADDR_PIN_LEVEL = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] ADDR_CHAN_INFO = 4'h8;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_EN_BIT = 2;
  localparam int SVC_VDS_LSB = 10;
  localparam int PIN_EN_BIT = 0;
  localparam int PIN_ECHO_BIT = 7;
  localparam int INFO_MODE_LSB = 4;
  localparam int IRQ_W = 6;
  localparam int IRQ_VDS_LSB = 0;
  localparam int IRQ_PIN_BIT = 4;
  localparam int IRQ_INT_BIT = 5;
  localparam logic [NCH-1:0] CHMASK_ONE = 4'h1;
  localparam logic [NCH-1:0] CHMASK_ALL = 4'hf;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
  localparam logic [15:0] RDATA_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    FSPC_OFF,
    FSPC_IDLE,
    FSPC_RUN
  } fspc_mode_t;

endpackage : fspc_pkg

// *** core/fspc_ctrl.sv ***
// Fail-safe switch pre-driver control: gates, VDS monitor, registers
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
module fspc_ctrl #(
  parameter int BLANK_CYCLES = fspc_pkg::VDS_MASK_CYCLES,
  parameter logic [1:0] PKG_CODE_FOUR = 2'h1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic driver_enable_pin,
  input wire logic clock_stuck_fault,
  input wire logic core_overvoltage_fault,
  input wire logic [fspc_pkg::NCH-1:0] vds_over_threshold,
  input wire logic nvm_load_done,
  input wire logic nvm_crc_error,
  input wire logic [1:0] nvm_package_code,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [fspc_pkg::NCH-1:0] safety_gate_out,
  output logic [fspc_pkg::NCH-1:0][1:0] vds_threshold_sel,
  output logic fault_irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic [1:0] int_s1;
    logic [1:0] int_s2;
    logic [fspc_pkg::NCH-1:0] vds_s1;
    logic [fspc_pkg::NCH-1:0] vds_s2;
    logic kill;
    logic loaded;
    logic [fspc_pkg::NCH-1:0] chmask;
    fspc_pkg::fspc_mode_t mode;
    logic [fspc_pkg::NCH-1:0][1:0] thr;
    logic [fspc_pkg::NCH-1:0] en;
    logic [fspc_pkg::NCH-1:0] gate;
    logic [fspc_pkg::NCH-1:0] fault;
    logic [fspc_pkg::NCH-1:0][fspc_pkg::CNT_W-1:0] blank_cnt;
    logic [fspc_pkg::NCH-1:0][fspc_pkg::CNT_W-1:0] flt_cnt;
    logic [fspc_pkg::IRQ_W-1:0] irq_stat;
    logic [fspc_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic [15:0] rdata;
  } fspc_state_t;

  localparam logic [fspc_pkg::CNT_W-1:0] BLANK_LOAD =
    fspc_pkg::CNT_W'(BLANK_CYCLES - 1);
  localparam logic [fspc_pkg::CNT_W-1:0] FILT_LAST =
    fspc_pkg::VDS_FILTER_CYCLES - 16'h0001;

  fspc_state_t st_reg;
  fspc_state_t st_next;

  logic kill_now;
  logic [fspc_pkg::NCH-1:0] vds_event;
  logic [fspc_pkg::IRQ_W-1:0] irq_event;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    vds_event = '0;
    irq_event = '0;
    st_next.rdata = fspc_pkg::RDATA_ZERO;

    // Two-stage synchronisers; first stages read by nothing else
    st_next.pin_s1 = driver_enable_pin;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.int_s1 = {core_overvoltage_fault, clock_stuck_fault};
    st_next.int_s2 = st_reg.int_s1;
    st_next.vds_s1 = vds_over_threshold;
    st_next.vds_s2 = st_reg.vds_s1;

    // internal faults kill gates
    // Kept apart from the enable logic so it acts regardless of config
    kill_now = !st_reg.pin_s2 || (st_reg.int_s2 != 2'h0);
    st_next.kill = kill_now;

    if (nvm_load_done && !st_reg.loaded) begin
      st_next.loaded = 1'b1;
      if (nvm_crc_error) begin
        st_next.chmask = fspc_pkg::CHMASK_ONE;
      end else if (nvm_package_code == PKG_CODE_FOUR) begin
        st_next.chmask = fspc_pkg::CHMASK_ALL;
      end else begin
        st_next.chmask = fspc_pkg::CHMASK_ONE;
      end
    end

    if (reg_rd && reg_addr == fspc_pkg::ADDR_SVC_FAULT) begin
      st_next.fault = '0;
    end

    // Software writes; ignored while still off
    if (reg_wr && st_reg.loaded) begin
      if (reg_addr <= fspc_pkg::ADDR_CFG_LAST) begin
        st_next.thr[reg_addr[1:0]] =
          reg_wdata[fspc_pkg::CFG_THR_LSB +: 2];
        st_next.en[reg_addr[1:0]] =
          reg_wdata[fspc_pkg::CFG_EN_BIT] && !st_reg.fault[reg_addr[1:0]];
      end else if (reg_addr == fspc_pkg::ADDR_IRQ_STAT) begin
        st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[fspc_pkg::IRQ_W-1:0];
      end else if (reg_addr == fspc_pkg::ADDR_IRQ_MASK) begin
        st_next.irq_mask = reg_wdata[fspc_pkg::IRQ_W-1:0];
      end
    end

    for (int i = 0; i < fspc_pkg::NCH; i++) begin
      if (st_reg.gate[i]) begin
        if (st_reg.blank_cnt[i] != '0) begin
          st_next.blank_cnt[i] = st_reg.blank_cnt[i] - 16'h0001;
          st_next.flt_cnt[i] = '0;
        end else if (st_reg.vds_s2[i]) begin
          if (st_reg.flt_cnt[i] == FILT_LAST) begin
            vds_event[i] = 1'b1;
          end else begin
            st_next.flt_cnt[i] = st_reg.flt_cnt[i] + 16'h0001;
          end
        end else begin
          st_next.flt_cnt[i] = '0;
        end
      end

      // fault latches and disables
      // Set wins over a clearing read in the same cycle
      if (vds_event[i]) begin
        st_next.fault[i] = 1'b1;
        st_next.en[i] = 1'b0;
      end

      st_next.gate[i] = st_reg.loaded && st_reg.chmask[i] &&
        st_next.en[i] && !st_next.fault[i] && !kill_now;

      if (st_next.gate[i] && !st_reg.gate[i]) begin
        st_next.blank_cnt[i] = BLANK_LOAD;
        st_next.flt_cnt[i] = '0;
      end else if (!st_next.gate[i]) begin
        st_next.blank_cnt[i] = '0;
        st_next.flt_cnt[i] = '0;
      end
    end

    irq_event[fspc_pkg::IRQ_VDS_LSB +: fspc_pkg::NCH] = vds_event;
    irq_event[fspc_pkg::IRQ_PIN_BIT] = !st_reg.pin_s2 && st_reg.loaded &&
      !(st_reg.kill && !(st_reg.int_s2 != 2'h0));
    irq_event[fspc_pkg::IRQ_INT_BIT] = (st_reg.int_s2 != 2'h0) &&
      !st_reg.kill;
    st_next.irq_stat = st_next.irq_stat | irq_event;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // idle once no gate is driven, e.g. on pin low or internal fault
    case (st_reg.mode)
      fspc_pkg::FSPC_OFF: begin
        if (st_next.loaded) begin
          st_next.mode = fspc_pkg::FSPC_IDLE;
        end
      end
      fspc_pkg::FSPC_IDLE: begin
        if (st_next.gate != '0) begin
          st_next.mode = fspc_pkg::FSPC_RUN;
        end
      end
      fspc_pkg::FSPC_RUN: begin
        if (st_next.gate == '0) begin
          st_next.mode = fspc_pkg::FSPC_IDLE;
        end
      end
      default: begin
        st_next.mode = fspc_pkg::FSPC_OFF;
      end
    endcase

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    if (reg_rd) begin
      if (reg_addr <= fspc_pkg::ADDR_CFG_LAST) begin
        st_next.rdata[fspc_pkg::CFG_THR_LSB +: 2] =
          st_reg.thr[reg_addr[1:0]];
        st_next.rdata[fspc_pkg::CFG_EN_BIT] = st_reg.en[reg_addr[1:0]];
      end else if (reg_addr == fspc_pkg::ADDR_SVC_FAULT) begin
        st_next.rdata[fspc_pkg::SVC_VDS_LSB +: fspc_pkg::NCH] =
          st_reg.fault;
      end else if (reg_addr == fspc_pkg::ADDR_PIN_LEVEL) begin
        st_next.rdata[fspc_pkg::PIN_EN_BIT] = st_reg.pin_s2;
        st_next.rdata[fspc_pkg::PIN_ECHO_BIT] = st_reg.kill;
      end else if (reg_addr == fspc_pkg::ADDR_IRQ_STAT) begin
        st_next.rdata[5:0] = st_reg.irq_stat;
      end else if (reg_addr == fspc_pkg::ADDR_IRQ_MASK) begin
        st_next.rdata[5:0] = st_reg.irq_mask;
      end else if (reg_addr == fspc_pkg::ADDR_CHAN_INFO) begin
        st_next.rdata[3:0] = st_reg.chmask;
        st_next.rdata[fspc_pkg::INFO_MODE_LSB +: 2] = st_reg.mode;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mode <= fspc_pkg::FSPC_OFF;
      st_reg.chmask <= fspc_pkg::CHMASK_ONE;
      st_reg.irq_mask <= fspc_pkg::IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign safety_gate_out = st_reg.gate;
  assign vds_threshold_sel = st_reg.thr;
  assign fault_irq = st_reg.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_kill_gate;
    @(posedge clock) disable iff (rst)
      !st_reg.pin_s2 |=> (st_reg.gate == '0) && st_reg.kill;
  endproperty
  a_kill_gate: assert property (p_kill_gate)
    else $error("gate high while enable pin low");

  property p_int_kill;
    @(posedge clock) disable iff (rst)
      (st_reg.int_s2 != 2'h0) |=> (st_reg.gate == '0);
  endproperty
  a_int_kill: assert property (p_int_kill)
    else $error("gate high during internal fault");

  property p_chan_mask;
    @(posedge clock) disable iff (rst)
      (st_reg.gate & ~st_reg.chmask) == '0;
  endproperty
  a_chan_mask: assert property (p_chan_mask)
    else $error("unsupported channel driven");

  property p_crc_default;
    @(posedge clock) disable iff (rst)
      nvm_load_done && nvm_crc_error && !st_reg.loaded
      |=> st_reg.chmask == fspc_pkg::CHMASK_ONE;
  endproperty
  a_crc_default: assert property (p_crc_default)
    else $error("checksum error did not force one channel");

  property p_fault_off;
    @(posedge clock) disable iff (rst)
      $rose(st_reg.fault[0]) |-> !st_reg.gate[0] && !st_reg.en[0]
      && $past(st_reg.gate[0]) && $past(st_reg.vds_s2[0]);
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("vds fault did not disable channel");

  property p_blank;
    @(posedge clock) disable iff (rst)
      $rose(st_reg.gate[0]) |=> !st_reg.fault[0] [*8];
  endproperty
  a_blank: assert property (p_blank)
    else $error("fault raised inside blanking");

  property p_read_clear;
    @(posedge clock) disable iff (rst)
      reg_rd && reg_addr == fspc_pkg::ADDR_SVC_FAULT && vds_event == '0
      |=> st_reg.fault == '0
      && st_reg.rdata[fspc_pkg::SVC_VDS_LSB +: fspc_pkg::NCH]
      == $past(st_reg.fault);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("fault read did not return and clear");

  property p_inhibit;
    @(posedge clock) disable iff (rst)
      st_reg.fault[0] |-> !st_reg.gate[0] && !st_reg.en[0];
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("channel active with fault latched");

  property p_pin_echo;
    @(posedge clock) disable iff (rst)
      reg_rd && reg_addr == fspc_pkg::ADDR_PIN_LEVEL
      |=> st_reg.rdata[0] == $past(st_reg.pin_s2)
      && st_reg.rdata[7] == $past(st_reg.kill);
  endproperty
  a_pin_echo: assert property (p_pin_echo)
    else $error("pin level report wrong");

  property p_irq;
    @(posedge clock) disable iff (rst)
      st_reg.irq == |(st_reg.irq_stat & st_reg.irq_mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("fault pin disagrees with masked status");

  property p_thr_sel;
    @(posedge clock) disable iff (rst)
      reg_wr && st_reg.loaded && reg_addr == fspc_pkg::ADDR_CFG_BASE
      |=> st_reg.thr[0] == $past(reg_wdata[fspc_pkg::CFG_THR_LSB +: 2]);
  endproperty
  a_thr_sel: assert property (p_thr_sel)
    else $error("threshold select not stored");

  property p_gate_en;
    @(posedge clock) disable iff (rst)
      st_reg.gate != '0
      |-> st_reg.loaded && ((st_reg.gate & ~st_reg.en) == '0);
  endproperty
  a_gate_en: assert property (p_gate_en)
    else $error("gate driven without software enable");

  property p_off_state;
    @(posedge clock) disable iff (rst)
      !st_reg.loaded |-> st_reg.gate == '0 && st_reg.en == '0
      && st_reg.mode == fspc_pkg::FSPC_OFF;
  endproperty
  a_off_state: assert property (p_off_state)
    else $error("off state left its defaults");

  property p_mode_run;
    @(posedge clock) disable iff (rst)
      st_reg.loaded |-> (st_reg.mode == fspc_pkg::FSPC_RUN)
      == (st_reg.gate != '0);
  endproperty
  a_mode_run: assert property (p_mode_run)
    else $error("running state disagrees with gate");

  property p_kill_idle;
    @(posedge clock) disable iff (rst)
      st_reg.kill |-> st_reg.mode != fspc_pkg::FSPC_RUN;
  endproperty
  a_kill_idle: assert property (p_kill_idle)
    else $error("running while switch-off path active");

  property p_blank_load;
    @(posedge clock) disable iff (rst)
      $rose(st_reg.gate[0]) |-> st_reg.blank_cnt[0] == BLANK_LOAD;
  endproperty
  a_blank_load: assert property (p_blank_load)
    else $error("blanking counter not restarted");

endmodule : fspc_ctrl

// *** verification/fspc_fet_model.sv ***
// Behavioural model of the external high-side safety switches
`timescale 1ns/10ps
module fspc_fet_model #(
  parameter int TURN_ON_CYCLES = 4
) (
  input wire logic clock,
  input wire logic [3:0] gate,
  input wire logic [3:0] short_to_gnd,
  output logic [3:0] vds_over
);
  // ----------------------------------------
  // Drain-source voltage per switch
  // ----------------------------------------
  int on_cnt [4];
  // Off switch sees full battery across it; a short never lets VDS fall
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (!gate[i]) begin
        on_cnt[i] <= 0;
      end else if (on_cnt[i] < TURN_ON_CYCLES) begin
        on_cnt[i] <= on_cnt[i] + 1;
      end
      vds_over[i] <= !gate[i] || short_to_gnd[i] ||
        on_cnt[i] < TURN_ON_CYCLES;
    end
  end
endmodule : fspc_fet_model

// *** verification/failsafe_switch_predriver_ctrl_tb.sv ***
// Self-checking bench of the safety switch pre-driver control
`timescale 1ns/10ps
module failsafe_switch_predriver_ctrl_tb;
  localparam int BLANK = 16;
  localparam logic [1:0] FOUR = 2'h1;
  logic clock = 1'b0, rst = 1'b1, pin = 1'b1, stuck = 1'b0, ovv = 1'b0;
  logic load = 1'b0, crc = 1'b0, rd = 1'b0, wr = 1'b0, irq;
  logic [1:0] code = 2'h0;
  logic [3:0] addr = 4'h0, vds, gate, shorts = 4'h0, eg = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, got;
  logic [3:0][1:0] thr;
  int mismatches = 0, n_tests = 0, n, ch, t, e;

  fspc_ctrl #(.BLANK_CYCLES(BLANK), .PKG_CODE_FOUR(FOUR)) uut (
    .clock(clock), .rst(rst), .driver_enable_pin(pin),
    .clock_stuck_fault(stuck), .core_overvoltage_fault(ovv),
    .vds_over_threshold(vds), .nvm_load_done(load), .nvm_crc_error(crc),
    .nvm_package_code(code), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .safety_gate_out(gate), .vds_threshold_sel(thr), .fault_irq(irq));
  fspc_fet_model fet (.clock(clock), .gate(gate), .short_to_gnd(shorts),
    .vds_over(vds));

  initial begin
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // Bus, compare and verdict tasks
  // ----------------------------------------
  task automatic cmp_rd(input logic [15:0] g, input logic [15:0] x);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected read at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp_rd
  task automatic cmp_out(input logic [3:0] g, input logic [3:0] x);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected output at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp_out
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : bus_rd
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : settle
  task automatic restart(input logic c_err, input logic [1:0] c_code);
    @(posedge clock);
    rst <= 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    crc <= c_err;
    code <= c_code;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    bus_wr(fspc_pkg::ADDR_IRQ_STAT, 16'h003f);
  endtask : restart
  function automatic logic [3:0] exp_mask(logic c_err, logic [1:0] c_code);
    return (!c_err && c_code == FOUR) ? 4'hf : 4'h1;
  endfunction : exp_mask

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(17));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    bus_wr(4'h1, 16'h0007);
    bus_rd(4'h1);
    cmp_rd(got, 16'h0000);
    bus_rd(fspc_pkg::ADDR_CHAN_INFO);
    cmp_rd(got & 16'h000f, 16'h0001);
    // Package options and checksum fallback
    for (int k = 0; k < 3; k++) begin
      restart(k == 0, (k == 1) ? 2'(FOUR + 2'h1) : FOUR);
      bus_rd(fspc_pkg::ADDR_CHAN_INFO);
      cmp_rd(got & 16'h000f, exp_mask(k == 0, code));
      bus_wr(4'h1, 16'h0004);
      settle(2);
      cmp_out(gate, exp_mask(k == 0, code) & 4'h2);
    end
    // Each threshold code on its own channel
    for (int i = 0; i < 4; i++) begin
      bus_wr(4'(i), 16'(i) | 16'h0004);
      settle(2);
      cmp_out({2'h0, thr[i]}, 4'(i));
    end
    cmp_out(gate, 4'hf);
    // Switch short on channel 0
    bus_wr(4'h0, 16'h0000);
    shorts <= 4'h1;
    bus_wr(4'h0, 16'h0004);
    n = 0;
    // Step off the launching edge before looking at the gate
    settle(0);
    while (gate[0] !== 1'b0 && n < 300) begin
      settle(1);
      n++;
    end
    cmp_out({3'h0, n >= BLANK + 54 && n <= BLANK + 80}, 4'h1);
    cmp_out(gate, 4'he);
    cmp_out({3'h0, irq}, 4'h0);
    bus_wr(fspc_pkg::ADDR_IRQ_MASK, 16'h0001);
    settle(2);
    cmp_out({3'h0, irq}, 4'h1);
    shorts <= 4'h0;
    bus_wr(4'h0, 16'h0004);
    settle(2);
    cmp_out(gate, 4'he);
    bus_rd(fspc_pkg::ADDR_SVC_FAULT);
    cmp_rd(got, 16'h0400);
    bus_rd(fspc_pkg::ADDR_SVC_FAULT);
    cmp_rd(got, 16'h0000);
    bus_wr(4'h0, 16'h0004);
    bus_wr(fspc_pkg::ADDR_IRQ_STAT, 16'h0001);
    settle(2);
    cmp_out(gate, 4'hf);
    cmp_out({3'h0, irq}, 4'h0);
    // Hardware inhibit and its echo
    pin <= 1'b0;
    settle(4);
    cmp_out(gate, 4'h0);
    bus_rd(fspc_pkg::ADDR_PIN_LEVEL);
    cmp_rd(got & 16'h0081, 16'h0080);
    bus_rd(4'h2);
    cmp_rd(got, 16'h0006);
    pin <= 1'b1;
    settle(4);
    bus_rd(fspc_pkg::ADDR_PIN_LEVEL);
    cmp_rd(got & 16'h0081, 16'h0001);
    cmp_out(gate, 4'hf);
    // Internal faults
    for (int k = 0; k < 2; k++) begin
      stuck <= (k == 0);
      ovv <= (k == 1);
      settle(4);
      cmp_out(gate, 4'h0);
      stuck <= 1'b0;
      ovv <= 1'b0;
      settle(4);
    end
    // Random configuration traffic and unmapped reads
    eg = 4'hf;
    for (int k = 0; k < 24; k++) begin
      ch = $urandom % 4;
      t = $urandom % 4;
      e = $urandom % 2;
      eg[ch] = e[0];
      bus_wr(4'(ch), 16'(t) | 16'(e << 2));
      settle(2);
      cmp_out(gate, eg);
      cmp_out({2'h0, thr[ch]}, 4'(t));
      bus_rd(4'(9 + $urandom % 7));
      cmp_rd(got, 16'h0000);
    end
    print_verdict();
  end
endmodule : failsafe_switch_predriver_ctrl_tb
